// [common/adt_pkg.sv]
/*
  adt_pkg: constants for the depressurization initiation timers.
  assumes a 250 MHz system clock.
*/
package adt_pkg;
  localparam int unsigned CLK_HZ          = 250_000_000;
  localparam int unsigned MAIN_DELAY_S    = 29;
  localparam int unsigned BYPASS_DELAY_MIN = 8;
  // longest times round down to whole cycles
  localparam longint unsigned MAIN_CYCLES =
    longint'(MAIN_DELAY_S) * longint'(CLK_HZ);
  localparam longint unsigned BYPASS_CYCLES =
    longint'(BYPASS_DELAY_MIN) * 64'd60 * longint'(CLK_HZ);
  localparam int unsigned NUM_DIV  = 2;
  localparam int unsigned NUM_CHAN = 4;
  localparam int unsigned VOTE_MIN = 2;
  localparam int unsigned CNT_W    = 40;
endpackage

// [core/adt_initiation.sv]
/*
  adt_initiation: two-division automatic depressurization initiation.
  assumes instrument and switch inputs are asynchronous plant levels.
*/
// Function
// - low level starts logic automatically
// - low level plus pressure starts main timer
// - main timer at most 29 seconds
// - main timer advances only during low level
// - low level without pressure starts bypass
// - bypass timer at most 8 minutes
// - bypass expiry with low level starts main
// - main expiry plus pump running actuates
// - two divisions, two-of-four voting of level and pressure channels
// - permissive or inhibit blocks automatic actuation
// - manual initiation plus pump running actuates
`timescale 1ns/100ps
module adt_initiation
  import adt_pkg::*;
#(
  parameter longint unsigned MAIN_CNT   = MAIN_CYCLES,
  parameter longint unsigned BYPASS_CNT = BYPASS_CYCLES
) (
  input  wire logic                clock_i,
  input  wire logic                sys_rst_i,
  input  wire logic [NUM_DIV*NUM_CHAN-1:0] low_level_chan_i,
  input  wire logic [NUM_DIV*NUM_CHAN-1:0] dw_press_chan_i,
  input  wire logic [NUM_DIV*NUM_CHAN-1:0] pump_run_chan_i,
  input  wire logic [NUM_DIV-1:0]  manual_init_i,
  input  wire logic                power_range_monitor_perm_i,
  input  wire logic                manual_inhibit_i,
  output wire logic [NUM_DIV-1:0]  actuate_o,
  output wire logic [NUM_DIV-1:0]  main_run_o,
  output wire logic [NUM_DIV-1:0]  bypass_run_o
);
  // timing notes for users of this block:
  // - every plant input passes two flip-flops, so logic reacts
  //   two edges after a change and the state moves on the third
  // - a timer counts whole clock cycles, so its span is the
  //   programmed count times the clock period, never longer
  // - a level drop shorter than one cycle may be missed; plant
  //   levels are slow, so this is accepted
  // - the two divisions share no state; only the switches, reset and
  //   the clock are common to both

  // timer sequence of one division
  typedef enum logic [1:0] {ST_IDLE, ST_BYPASS, ST_MAIN, ST_DONE} adt_st_e;

  // layout of the synchronised input vector, lowest bit first
  localparam int unsigned NV = NUM_DIV*NUM_CHAN;  // bits per variable
  localparam int unsigned NI = 3*NV + NUM_DIV + 2;
  localparam int unsigned IH = 0;                 // manual inhibit bit
  localparam int unsigned PM = 1;                 // permissive bit
  localparam int unsigned MI = 2;                 // manual init base
  localparam int unsigned PU = MI + NUM_DIV;      // pump base
  localparam int unsigned PR = PU + NV;           // pressure base
  localparam int unsigned LO = PR + NV;           // low level base

  // last count of each timer, cut to the counter width
  localparam logic [CNT_W-1:0] MAIN_LAST   = CNT_W'(MAIN_CNT - 1);
  localparam logic [CNT_W-1:0] BYPASS_LAST = CNT_W'(BYPASS_CNT - 1);

  // two-flop synchronisers for all plant inputs
  logic [NI-1:0] sync1_ff;
  logic [NI-1:0] sync2_ff;

  // first stage samples the raw plant levels
  always_ff @(posedge clock_i) begin
    sync1_ff <= {low_level_chan_i, dw_press_chan_i, pump_run_chan_i,
                 manual_init_i, power_range_monitor_perm_i,
                 manual_inhibit_i};
  end

  // second stage, the only reader of the first
  always_ff @(posedge clock_i) begin
    sync2_ff <= sync1_ff;
  end

  // settled copies of each plant variable
  logic [NV-1:0]      low_sync;
  logic [NV-1:0]      prs_sync;
  logic [NV-1:0]      pump_sync;
  logic [NUM_DIV-1:0] man_sync;
  logic               perm_sync;
  logic               inh_sync;
  logic               block_auto;

  // split the second stage into its variables
  assign low_sync  = sync2_ff[LO +: NV];
  assign prs_sync  = sync2_ff[PR +: NV];
  assign pump_sync = sync2_ff[PU +: NV];
  assign man_sync  = sync2_ff[MI +: NUM_DIV];
  assign perm_sync = sync2_ff[PM];
  assign inh_sync  = sync2_ff[IH];

  // inhibit blocks automatic
  // either switch masks the timer path, never the manual one
  assign block_auto = perm_sync | inh_sync;

  genvar d;
  generate
    for (d = 0; d < NUM_DIV; d++) begin : g_div
      // channel groups of this division
      logic [NUM_CHAN-1:0] lvl;
      logic [NUM_CHAN-1:0] prs;
      logic [NUM_CHAN-1:0] pmp;
      logic                low_trip;
      logic                prs_trip;
      logic                pump_trip;

      // timer state and its next value
      adt_st_e             state_ff;
      adt_st_e             nxt_state;
      logic [CNT_W-1:0]    cnt_ff;
      logic [CNT_W-1:0]    nxt_cnt;
      logic                byp_expired;
      logic                main_expired;

      // actuation requests
      logic                auto_req;
      logic                man_req;
      logic                act_ff;
      logic                nxt_act;

      // this division's four channels of each variable
      assign lvl = low_sync[d*NUM_CHAN +: NUM_CHAN];
      assign prs = prs_sync[d*NUM_CHAN +: NUM_CHAN];
      assign pmp = pump_sync[d*NUM_CHAN +: NUM_CHAN];

      // two-of-four voting
      // a single failed channel can neither trip nor block a trip
      assign low_trip  = $countones(lvl) >= VOTE_MIN;
      assign prs_trip  = $countones(prs) >= VOTE_MIN;
      // any running pump is positive indication
      assign pump_trip = |pmp;

      assign byp_expired  = (cnt_ff >= BYPASS_LAST);
      assign main_expired = (cnt_ff >= MAIN_LAST);

      // next state of the timer sequence
      always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
          ST_IDLE: begin
            if (low_trip) begin
              if (prs_trip)
                nxt_state = ST_MAIN;
              else
                nxt_state = ST_BYPASS;
            end
          end
          ST_BYPASS: begin
            if (!low_trip)
              nxt_state = ST_IDLE;
            else if (byp_expired)
              nxt_state = ST_MAIN;
            // pressure arriving skips the rest of bypass
            else if (prs_trip)
              nxt_state = ST_MAIN;
          end
          ST_MAIN: begin
            if (!low_trip)
              nxt_state = ST_IDLE;
            else if (main_expired)
              nxt_state = ST_DONE;
          end
          ST_DONE: begin
            // expired timer holds until low level clears
            if (!low_trip)
              nxt_state = ST_IDLE;
          end
        endcase
      end

      // next count: restart on any state change, step while timing
      always_comb begin
        nxt_cnt = cnt_ff;
        if (nxt_state != state_ff)
          nxt_cnt = '0;
        else if (state_ff == ST_BYPASS || state_ff == ST_MAIN)
          nxt_cnt = cnt_ff + 1'b1;
        else if (state_ff == ST_IDLE)
          nxt_cnt = '0;
      end

      // timer state register
      always_ff @(posedge clock_i) begin
        if (sys_rst_i)
          state_ff <= ST_IDLE;
        else
          state_ff <= nxt_state;
      end

      // counter clears on leaving
      // a stale count would shorten the next timing run
      always_ff @(posedge clock_i) begin
        if (sys_rst_i)
          cnt_ff <= '0;
        else
          cnt_ff <= nxt_cnt;
      end

      assign auto_req = (state_ff == ST_DONE) && !block_auto;
      assign man_req  = man_sync[d];
      // no pump running means no actuation on either path
      assign nxt_act  = pump_trip & (auto_req | man_req);

      // actuation output register
      always_ff @(posedge clock_i) begin
        if (sys_rst_i)
          act_ff <= 1'b0;
        else
          act_ff <= nxt_act;
      end

      // status and drive outputs of this division
      assign actuate_o[d]    = act_ff;
      assign main_run_o[d]   = (state_ff == ST_MAIN);
      assign bypass_run_o[d] = (state_ff == ST_BYPASS);
    end
  endgenerate
endmodule

// [tb/adt_plant.sv]
/* adt_plant: level channels that trip the first n of four.
   assumes the bench gives a trip count of 0 to 4. */
`timescale 1ns/100ps
module adt_plant (
  input  logic [2:0] trip_n_i,
  output logic [3:0] chan_o
);
  // channels above the trip count stay clear
  assign chan_o = 4'hF >> (3'h4 - trip_n_i);
endmodule

// [tb/adt_monitor.sv]
/* adt_monitor: timer and actuation checks.
   assumes a bind onto adt_initiation, one clock. */
`timescale 1ns/100ps
module adt_monitor #(parameter longint unsigned MAIN_CNT = 20,
  BYPASS_CNT = 50) (
  input logic       clock_i, sys_rst_i, manual_inhibit_i,
  input logic       power_range_monitor_perm_i,
  input logic [7:0] low_level_chan_i, dw_press_chan_i, pump_run_chan_i,
  input logic [1:0] manual_init_i, actuate_o, main_run_o, bypass_run_o
);
  localparam int MX = int'(MAIN_CNT) + 3, BX = int'(BYPASS_CNT) + 3;
  // two-channel votes of division 0 and the automatic block
  wire lo = &low_level_chan_i[1:0], pr = &dw_press_chan_i[1:0];
  wire blk = power_range_monitor_perm_i | manual_inhibit_i;
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  both_run_a: assert property (!(main_run_o[0] & bypass_run_o[0]))
    else $error("both timers run");
  main_len_a: assert property ($rose(main_run_o[0]) |-> ##[1:MX]
    !main_run_o[0]) else $error("main timer too long");
  byp_len_a: assert property ($rose(bypass_run_o[0]) |-> ##[1:BX]
    !bypass_run_o[0]) else $error("bypass timer too long");
  auto_blk_a: assert property ((blk & !manual_init_i[0])[*5] |->
    !actuate_o[0]) else $error("actuated while blocked");
  no_pump_a: assert property ((!pump_run_chan_i[3:0])[*5] |->
    !actuate_o[0]) else $error("actuated without pump");
  low_idle_a: assert property ((!low_level_chan_i[3:0])[*5] |->
    !(main_run_o[0] | bypass_run_o[0])) else $error("timer without low");
  man_act_a: assert property ((manual_init_i[1]
    & |pump_run_chan_i[7:4])[*5] |-> actuate_o[1]) else $error("no manual");
  main_go_a: assert property ($rose(lo) & pr ##1 (lo & pr)[*4] |->
    main_run_o[0]) else $error("main timer idle");
  cover property (actuate_o[0]);
  cover property (bypass_run_o[0] ##1 main_run_o[0]);
  cover property (actuate_o[1] & blk);
endmodule
bind adt_initiation adt_monitor #(.MAIN_CNT(MAIN_CNT),
  .BYPASS_CNT(BYPASS_CNT)) adt_monitor_i (.*);

// [tb/depressurization_initiation_timers_tb_top.sv]
/* bench top: plant levels, switches and checks of all outputs.
   assumes short timer counts of 20 and 50 cycles. */
`timescale 1ns/100ps
module depressurization_initiation_timers_tb_top;
  logic        clock_i = 0, sys_rst_i = 1;
  logic [1:0]  inh = 0, man = 0;
  logic [2:0]  ln = 0;
  logic [3:0]  lo, pr = 0;
  logic [5:0]  o;
  logic [7:0]  pump = 0;
  logic [31:0] rnd = 32'h00014506;
  int          err_count = 0, num_checks = 0;
  adt_plant adt_plant_i (.trip_n_i(ln), .chan_o(lo));
  adt_initiation #(.MAIN_CNT(20), .BYPASS_CNT(50)) adt_initiation_i (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .low_level_chan_i({lo, lo}),
    .dw_press_chan_i({pr, pr}), .pump_run_chan_i(pump), .manual_init_i(man),
    .power_range_monitor_perm_i(inh[1]), .manual_inhibit_i(inh[0]),
    .actuate_o(o[5:4]), .bypass_run_o(o[3:2]), .main_run_o(o[1:0]));
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], ^(s & 32'h80200003)};
  endfunction
  // set levels, wait n falling edges, compare {actuate, bypass, main}
  task automatic st(input logic [2:0] l, input logic [3:0] p, input int n,
                    input logic [5:0] e);
    ln = l;
    pr = p;
    repeat (n) @(negedge clock_i);
    num_checks++;
    err_count += int'(o !== e);
    if (o !== e) $display("unexpected %0t %h %h", $time, o, e);
  endtask
  task automatic test_done(input int e);
    err_count += e;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial forever #2 clock_i = ~clock_i;
  // run needs about 130 cycles; cut a hang at over twice that
  initial #1200 test_done(1);
  initial begin
    st(3'h0, 4'h0, 10, 6'h00);
    sys_rst_i = 0;
    st(3'h0, 4'h0, 6, 6'h00);
    st(3'h1, 4'h1, 6, 6'h00);
    rnd = nx(rnd);
    pump = 8'h11 << rnd[3:2];
    st(3'h2 + rnd[0], 4'hF >> rnd[1], 4, 6'h03);
    st(ln, pr, 21, 6'h30);
    st(3'h0, pr, 5, 6'h00);
    st(3'h4, 4'h0, 4, 6'h0C);
    st(3'h4, 4'h0, 50, 6'h03);
    inh = 2'h1 + rnd[4];
    st(3'h4, 4'h0, 22, 6'h00);
    man = 2'h2;
    st(3'h4, 4'h0, 6, 6'h20);
    test_done(0);
  end
endmodule
